// File: cwd_pkg.sv
// constants and types shared by the card write/erase command decoder
`default_nettype none
package cwd_pkg;
  // command indexes
  localparam logic [5:0] CWD_IDX_BLOCKLEN = 6'h10;
  localparam logic [5:0] CWD_IDX_STOP = 6'h0C;
  localparam logic [5:0] CWD_IDX_STREAM_WR = 6'h14;
  localparam logic [5:0] CWD_IDX_BLK_COUNT = 6'h17;
  localparam logic [5:0] CWD_IDX_WR_SINGLE = 6'h18;
  localparam logic [5:0] CWD_IDX_WR_MULTI = 6'h19;
  localparam logic [5:0] CWD_IDX_PROG_ID = 6'h1A;
  localparam logic [5:0] CWD_IDX_PROG_CSD = 6'h1B;
  localparam logic [5:0] CWD_IDX_SET_WP = 6'h1C;
  localparam logic [5:0] CWD_IDX_CLR_WP = 6'h1D;
  localparam logic [5:0] CWD_IDX_SEND_WP = 6'h1E;
  localparam logic [5:0] CWD_IDX_RSV_LO = 6'h20;
  localparam logic [5:0] CWD_IDX_RSV_HI = 6'h22;
  localparam logic [5:0] CWD_IDX_ERASE_START = 6'h23;
  localparam logic [5:0] CWD_IDX_ERASE_END = 6'h24;
  localparam logic [5:0] CWD_IDX_RSV_37 = 6'h25;
  localparam logic [5:0] CWD_IDX_ERASE = 6'h26;
  localparam logic [5:0] CWD_IDX_IO_LO = 6'h27;
  localparam logic [5:0] CWD_IDX_IO_HI = 6'h28;
  // response frame layout
  localparam int CWD_RESP_BITS = 48;
  localparam int CWD_RESP_IDX_LSB = 40;
  localparam int CWD_RESP_STAT_LSB = 8;
  // block count field of the set-count argument
  localparam int CWD_CNT_MSB = 15;
  // reset values
  localparam logic [15:0] CWD_BLKLEN_RST = 16'h0200;
  // response kinds
  typedef enum logic [1:0] {CWD_RSP_NONE, CWD_RSP_R1, CWD_RSP_R1B} cwd_rsp_t;
  // decoder states
  typedef enum logic [2:0] {
    CWD_ST_IDLE, CWD_ST_STREAM, CWD_ST_BLOCK, CWD_ST_BUSY
  } cwd_state_t;
endpackage
`default_nettype wire

// File: cwd_wp_table.sv
// write protection bit table, one bit per protection group
`default_nettype none
module cwd_wp_table
  import cwd_pkg::*;
#(
  parameter int GROUPS = 32,
  parameter int GW = 5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic set_en,
  input wire logic clr_en,
  input wire logic [GW-1:0] grp,
  output logic [GROUPS-1:0] wp_bits
);
  logic [GROUPS-1:0] wp_q; // protection bits
  logic [GROUPS-1:0] wp_d; // next value
  // one update term per group
  for (genvar g = 0; g < GROUPS; g++) begin : g_bit
    always_comb begin
      wp_d[g] = wp_q[g];
      if (set_en && grp == GW'(g)) begin
        wp_d[g] = 1'b1; // set protection
      end else if (clr_en && grp == GW'(g)) begin
        wp_d[g] = 1'b0; // clear protection
      end
    end
  end
  // register stage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
    end else if (clk_en) begin
      wp_q <= wp_d;
    end
  end
  assign wp_bits = wp_q;
endmodule
`default_nettype wire

// File: cwd_decoder.sv
// card-side decoder for write, protection and erase commands
// Overview of operation
// [RULE_01] stream write runs until stop command
// [RULE_02] set-count holds low 16 bits, next multi
// [RULE_03] single write takes exactly one block
// [RULE_04] multi write ends on stop or count
// [RULE_05] identification program refused after first time
// [RULE_06] host programs identification once only
// [RULE_07] csd program takes data, updates programmable bits
// [RULE_08] set-protection sets addressed group bit
// [RULE_09] group size comes from csd field
// [RULE_10] clear-protection clears group bit, busy response
// [RULE_11] status query sends protection bits as data
// [RULE_12] indexes 32-34 and 37 not implemented
// [RULE_13] erase start records first group address
// [RULE_14] erase end records last group address
// [RULE_15] erase wipes selected range, busy response
// [RULE_16] io mode class indexes unsupported
// [RULE_17] block length sets following block size
// [RULE_18] response 48 bits, index echo, status
// [RULE_19] busy held until operation finishes
`default_nettype none
module cwd_decoder
  import cwd_pkg::*;
#(
  parameter int GROUPS = 32,
  parameter int GW = 5
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic [31:0] cmd_arg,
  input wire logic [31:0] card_status,
  input wire logic [4:0] wp_grp_shift,
  input wire logic wp_supported,
  input wire logic data_block_done,
  input wire logic op_done,
  output logic rsp_valid,
  output logic [47:0] rsp_frame,
  output logic rsp_busy_type,
  output logic cmd_illegal,
  output logic busy,
  output logic wr_active,
  output logic wr_stream,
  output logic [31:0] wr_addr,
  output logic [15:0] blk_len,
  output logic id_prog_en,
  output logic csd_prog_en,
  output logic wp_send,
  output logic [GROUPS-1:0] wp_status,
  output logic erase_go,
  output logic [31:0] erase_first,
  output logic [31:0] erase_last
);
  cwd_state_t st_q, st_d; // transfer state
  logic [15:0] cnt_q, cnt_d; // preset block count, zero means open
  logic cnt_arm_q, cnt_arm_d; // count valid for next command
  logic [15:0] left_q, left_d; // blocks still owed
  logic id_done_q, id_done_d; // identification already programmed
  logic [15:0] blen_q, blen_d; // block length
  logic [31:0] addr_q, addr_d; // transfer address
  logic [31:0] es_q, es_d; // erase first
  logic [31:0] ee_q, ee_d; // erase last
  logic rv_q, rv_d; // response strobe
  logic [47:0] rf_q, rf_d; // response frame
  logic rb_q, rb_d; // busy-type response
  logic il_q, il_d; // illegal pulse
  logic str_q, str_d; // stream mode
  logic idp_q, idp_d; // id program strobe
  logic csp_q, csp_d; // csd program strobe
  logic wps_q, wps_d; // protection send strobe
  logic er_q, er_d; // erase strobe
  logic wp_set, wp_clr; // protection table updates
  logic [GW-1:0] grp; // addressed group
  logic [GROUPS-1:0] wp_bits; // table contents
  logic [31:0] grp_full; // shifted address
  // group index from the address and the csd group size
  assign grp_full = cmd_arg >> wp_grp_shift; // [RULE_09]
  assign grp = grp_full[GW-1:0];
  // protection table
  cwd_wp_table #(.GROUPS(GROUPS), .GW(GW)) u_wp (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .set_en(wp_set),
    .clr_en(wp_clr),
    .grp(grp),
    .wp_bits(wp_bits)
  );
  // command decode and next state
  always_comb begin
    cwd_rsp_t rk;
    rk = CWD_RSP_NONE;
    st_d = st_q;
    cnt_d = cnt_q;
    cnt_arm_d = cnt_arm_q;
    left_d = left_q;
    id_done_d = id_done_q;
    blen_d = blen_q;
    addr_d = addr_q;
    es_d = es_q;
    ee_d = ee_q;
    str_d = str_q;
    il_d = 1'b0;
    idp_d = 1'b0;
    csp_d = 1'b0;
    wps_d = 1'b0;
    er_d = 1'b0;
    wp_set = 1'b0;
    wp_clr = 1'b0;
    // block accounting in write state
    if (st_q == CWD_ST_BLOCK && data_block_done) begin
      if (left_q == 16'h0001) begin
        st_d = CWD_ST_IDLE; // single or counted transfer complete [RULE_03] [RULE_04]
      end
      if (left_q != 16'h0000) begin
        left_d = left_q - 16'h0001;
      end
    end
    // busy ends when the operation reports done
    if (st_q == CWD_ST_BUSY && op_done) begin
      st_d = CWD_ST_IDLE; // [RULE_19]
    end
    if (cmd_valid) begin
      if (cmd_index != CWD_IDX_WR_MULTI) begin
        cnt_arm_d = 1'b0; // count only for the next command [RULE_02]
      end
      case (cmd_index)
        CWD_IDX_STOP: begin
          if (st_q == CWD_ST_STREAM || st_q == CWD_ST_BLOCK) begin
            st_d = CWD_ST_IDLE; // [RULE_01] [RULE_04]
            str_d = 1'b0;
          end
          rk = CWD_RSP_R1;
        end
        CWD_IDX_BLOCKLEN: begin
          blen_d = cmd_arg[15:0]; // [RULE_17]
          rk = CWD_RSP_R1;
        end
        CWD_IDX_STREAM_WR: begin
          addr_d = cmd_arg;
          st_d = CWD_ST_STREAM; // [RULE_01]
          str_d = 1'b1;
          rk = CWD_RSP_R1;
        end
        CWD_IDX_BLK_COUNT: begin
          cnt_d = cmd_arg[CWD_CNT_MSB:0]; // [RULE_02]
          cnt_arm_d = 1'b1;
          rk = CWD_RSP_R1;
        end
        CWD_IDX_WR_SINGLE: begin
          addr_d = cmd_arg;
          left_d = 16'h0001; // [RULE_03]
          st_d = CWD_ST_BLOCK;
          rk = CWD_RSP_R1;
        end
        CWD_IDX_WR_MULTI: begin
          addr_d = cmd_arg;
          left_d = cnt_arm_q ? cnt_q : 16'h0000; // [RULE_04]
          cnt_arm_d = 1'b0;
          st_d = CWD_ST_BLOCK;
          rk = CWD_RSP_R1;
        end
        CWD_IDX_PROG_ID: begin
          if (id_done_q) begin
            il_d = 1'b1; // second programming refused [RULE_05]
          end else begin
            id_done_d = 1'b1;
            idp_d = 1'b1;
            left_d = 16'h0001;
            st_d = CWD_ST_BLOCK;
            rk = CWD_RSP_R1;
          end
        end
        CWD_IDX_PROG_CSD: begin
          csp_d = 1'b1; // [RULE_07]
          left_d = 16'h0001;
          st_d = CWD_ST_BLOCK;
          rk = CWD_RSP_R1;
        end
        CWD_IDX_SET_WP: begin
          wp_set = wp_supported; // [RULE_08]
          rk = CWD_RSP_R1;
        end
        CWD_IDX_CLR_WP: begin
          wp_clr = wp_supported; // [RULE_10]
          st_d = CWD_ST_BUSY;
          rk = CWD_RSP_R1B;
        end
        CWD_IDX_SEND_WP: begin
          wps_d = 1'b1; // [RULE_11]
          rk = CWD_RSP_R1;
        end
        CWD_IDX_ERASE_START: begin
          es_d = cmd_arg; // [RULE_13]
          rk = CWD_RSP_R1;
        end
        CWD_IDX_ERASE_END: begin
          ee_d = cmd_arg; // [RULE_14]
          rk = CWD_RSP_R1;
        end
        CWD_IDX_ERASE: begin
          er_d = 1'b1; // [RULE_15]
          st_d = CWD_ST_BUSY;
          rk = CWD_RSP_R1B;
        end
        default: begin
          // reserved and io-mode indexes, and all others here
          il_d = (cmd_index >= CWD_IDX_RSV_LO && cmd_index <= CWD_IDX_RSV_HI) ||
                 cmd_index == CWD_IDX_RSV_37 || // [RULE_12]
                 (cmd_index >= CWD_IDX_IO_LO && cmd_index <= CWD_IDX_IO_HI); // [RULE_16]
        end
      endcase
    end
    // response frame: start, direction, index, status, crc slot, end
    rv_d = (rk != CWD_RSP_NONE);
    rb_d = (rk == CWD_RSP_R1B);
    rf_d = rf_q;
    if (rv_d) begin
      rf_d = {2'b00, cmd_index, card_status, 7'h00, 1'b1}; // [RULE_18]
    end
  end
  // state registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= CWD_ST_IDLE;
      cnt_q <= '0;
      cnt_arm_q <= 1'b0;
      left_q <= '0;
      id_done_q <= 1'b0;
      blen_q <= CWD_BLKLEN_RST;
      addr_q <= '0;
      es_q <= '0;
      ee_q <= '0;
      rv_q <= 1'b0;
      rf_q <= '0;
      rb_q <= 1'b0;
      il_q <= 1'b0;
      str_q <= 1'b0;
      idp_q <= 1'b0;
      csp_q <= 1'b0;
      wps_q <= 1'b0;
      er_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cnt_arm_q <= cnt_arm_d;
      left_q <= left_d;
      id_done_q <= id_done_d;
      blen_q <= blen_d;
      addr_q <= addr_d;
      es_q <= es_d;
      ee_q <= ee_d;
      rv_q <= rv_d;
      rf_q <= rf_d;
      rb_q <= rb_d;
      il_q <= il_d;
      str_q <= str_d;
      idp_q <= idp_d;
      csp_q <= csp_d;
      wps_q <= wps_d;
      er_q <= er_d;
    end
  end
  // outputs
  assign rsp_valid = rv_q;
  assign rsp_frame = rf_q;
  assign rsp_busy_type = rb_q;
  assign cmd_illegal = il_q;
  assign busy = (st_q == CWD_ST_BUSY); // [RULE_19]
  assign wr_active = (st_q == CWD_ST_BLOCK) || (st_q == CWD_ST_STREAM);
  assign wr_stream = str_q;
  assign wr_addr = addr_q;
  assign blk_len = blen_q;
  assign id_prog_en = idp_q;
  assign csd_prog_en = csp_q;
  assign wp_send = wps_q;
  assign wp_status = wp_bits;
  assign erase_go = er_q;
  assign erase_first = es_q;
  assign erase_last = ee_q;
  // checks
  property p_stream_hold; // [RULE_01]
    @(posedge core_clk) disable iff (!rst_b)
    (st_q == CWD_ST_STREAM && !(cmd_valid && cmd_index == CWD_IDX_STOP) && clk_en)
      |=> st_q == CWD_ST_STREAM;
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream ended early"); // [RULE_01]
  property p_id_once; // [RULE_05]
    @(posedge core_clk) disable iff (!rst_b)
    (id_done_q && cmd_valid && cmd_index == CWD_IDX_PROG_ID && clk_en)
      |=> cmd_illegal && !id_prog_en && !rsp_valid;
  endproperty
  a_id_once: assert property (p_id_once) else $error("id programmed twice"); // [RULE_05]
  property p_rsv; // [RULE_12]
    @(posedge core_clk) disable iff (!rst_b)
    (cmd_valid && clk_en && (cmd_index == CWD_IDX_RSV_37 || cmd_index == CWD_IDX_RSV_LO))
      |=> cmd_illegal && !rsp_valid;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved index accepted"); // [RULE_12]
  property p_io; // [RULE_16]
    @(posedge core_clk) disable iff (!rst_b)
    (cmd_valid && clk_en && cmd_index == CWD_IDX_IO_LO) |=> cmd_illegal;
  endproperty
  a_io: assert property (p_io) else $error("io index accepted"); // [RULE_16]
  property p_echo; // [RULE_18]
    @(posedge core_clk) disable iff (!rst_b)
    rsp_valid |-> rsp_frame[47:46] == 2'b00 && rsp_frame[0] &&
      rsp_frame[45:40] == $past(cmd_index);
  endproperty
  a_echo: assert property (p_echo) else $error("bad response frame"); // [RULE_18]
  property p_erase_busy; // [RULE_15]
    @(posedge core_clk) disable iff (!rst_b)
    (cmd_valid && clk_en && cmd_index == CWD_IDX_ERASE)
      |=> erase_go && rsp_busy_type && busy;
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase not busy"); // [RULE_15]
  property p_busy_end; // [RULE_19]
    @(posedge core_clk) disable iff (!rst_b)
    (busy && op_done && clk_en) |=> !busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not released"); // [RULE_19]
  property p_single; // [RULE_03]
    @(posedge core_clk) disable iff (!rst_b)
    (st_q == CWD_ST_BLOCK && left_q == 16'h0001 && data_block_done && clk_en &&
     !cmd_valid) |=> !wr_active;
  endproperty
  a_single: assert property (p_single) else $error("block count overrun"); // [RULE_03]
  property p_estart; // [RULE_13]
    @(posedge core_clk) disable iff (!rst_b)
    (cmd_valid && clk_en && cmd_index == CWD_IDX_ERASE_START)
      |=> erase_first == $past(cmd_arg);
  endproperty
  a_estart: assert property (p_estart) else $error("erase start lost"); // [RULE_13]
  c_stream: cover property (@(posedge core_clk) disable iff (!rst_b) wr_stream);
  c_erase: cover property (@(posedge core_clk) disable iff (!rst_b) erase_go);
  c_busy_done: cover property (@(posedge core_clk) disable iff (!rst_b) busy ##1 !busy);
endmodule
`default_nettype wire

// File: cwd_host_model.sv
// host controller model that issues decoded commands to the card decoder
`default_nettype none
module cwd_host_model
  import cwd_pkg::*;
(
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [5:0] cmd_index,
  output logic [31:0] cmd_arg
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle command port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_index = 6'h00;
    cmd_arg = 32'h0;
  end
  // one command per call: raised after an edge, dropped after the taking edge
  // repeated id programming and reserved indexes only when a test asks
  task automatic issue(input logic [5:0] idx, input logic [31:0] arg);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_index = idx;
    // count command keeps its upper half zero
    cmd_arg = (idx == CWD_IDX_BLK_COUNT) ? {16'h0000, arg[15:0]} : arg;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    // released fields show inverted values, which can be other command indexes; only cmd_valid low marks them stale
    cmd_index = ~idx;
    cmd_arg = ~cmd_arg;
  endtask
endmodule
`default_nettype wire

// File: card_write_erase_cmd_decoder_bench.sv
// self-checking bench for the card write/erase command decoder
`default_nettype none
module card_write_erase_cmd_decoder_bench
  import cwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1; // freeze control for the decoder
  logic cmd_valid, wp_supported = 1'b1, data_block_done = 1'b0, op_done = 1'b0;
  logic [5:0] cmd_index;
  logic [31:0] cmd_arg, wr_addr, erase_first, erase_last;
  logic [31:0] card_status = 32'hA5C30F96;
  logic [4:0] wp_grp_shift = 5'h04;
  logic rsp_valid, rsp_busy_type, cmd_illegal, busy, wr_active, wr_stream;
  logic id_prog_en, csd_prog_en, wp_send, erase_go;
  logic [47:0] rsp_frame;
  logic [15:0] blk_len;
  logic [31:0] wp_status;
  int miscompares = 0, num_checks = 0, cycles = 0;
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  cwd_host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .cmd_arg(cmd_arg));
  cwd_decoder uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_index(cmd_index), .cmd_arg(cmd_arg), .card_status(card_status),
    .wp_grp_shift(wp_grp_shift), .wp_supported(wp_supported),
    .data_block_done(data_block_done), .op_done(op_done), .rsp_valid(rsp_valid),
    .rsp_frame(rsp_frame), .rsp_busy_type(rsp_busy_type), .cmd_illegal(cmd_illegal),
    .busy(busy), .wr_active(wr_active), .wr_stream(wr_stream), .wr_addr(wr_addr),
    .blk_len(blk_len), .id_prog_en(id_prog_en), .csd_prog_en(csd_prog_en),
    .wp_send(wp_send), .wp_status(wp_status), .erase_go(erase_go),
    .erase_first(erase_first), .erase_last(erase_last));
  // value compare
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // response present with index echo, status and busy kind
  task automatic rsp(input logic [5:0] idx, input logic bt);
    chk(rsp_valid, 1'b1);
    chk(rsp_busy_type, bt);
    chk(rsp_frame, {2'b00, idx, card_status, 7'h00, 1'b1});
  endtask
  // one-cycle block-done or operation-done pulse
  task automatic done(input bit op);
    @(posedge core_clk);
    #1;
    if (op) op_done = 1'b1;
    else data_block_done = 1'b1;
    @(posedge core_clk);
    #1;
    op_done = 1'b0;
    data_block_done = 1'b0;
  endtask
  // reset values and block length
  task automatic t_len();
    chk(blk_len, 16'h0200);
    chk({busy, wr_active}, 2'b00);
    host.issue(CWD_IDX_BLOCKLEN, 32'h40);
    rsp(CWD_IDX_BLOCKLEN, 1'b0);
    chk(blk_len, 16'h0040);
    $display("done length");
  endtask
  // clock enable low: a command is not taken and state holds
  task automatic t_freeze();
    @(posedge core_clk);
    #1;
    clk_en = 1'b0;
    host.issue(CWD_IDX_BLOCKLEN, 32'h80);
    chk(rsp_valid, 1'b0);
    chk(blk_len, 16'h0040);
    clk_en = 1'b1;
    @(posedge core_clk);
    #1;
    chk({rsp_valid, blk_len}, {1'b0, 16'h0040});
    $display("done freeze");
  endtask
  // single block write closes after one block
  task automatic t_single();
    host.issue(CWD_IDX_WR_SINGLE, 32'h12345678);
    rsp(CWD_IDX_WR_SINGLE, 1'b0);
    chk({wr_active, wr_stream}, 2'b10);
    chk(wr_addr, 32'h12345678);
    done(0);
    chk(wr_active, 1'b0);
    $display("done single");
  endtask
  // stream write outlives blocks until stop
  task automatic t_stream();
    host.issue(CWD_IDX_STREAM_WR, 32'h00ABCDEF);
    rsp(CWD_IDX_STREAM_WR, 1'b0);
    chk({wr_active, wr_stream}, 2'b11);
    chk(wr_addr, 32'h00ABCDEF);
    done(0);
    done(0);
    chk(wr_active, 1'b1);
    host.issue(CWD_IDX_STOP, 32'h0);
    chk(wr_active, 1'b0);
    $display("done stream");
  endtask
  // multi write with preset count, and a count lost to an intervening command
  task automatic t_multi();
    host.issue(CWD_IDX_BLK_COUNT, 32'h2);
    rsp(CWD_IDX_BLK_COUNT, 1'b0);
    host.issue(CWD_IDX_WR_MULTI, 32'h400);
    done(0);
    chk(wr_active, 1'b1);
    done(0);
    chk(wr_active, 1'b0);
    host.issue(CWD_IDX_BLK_COUNT, 32'h1);
    host.issue(CWD_IDX_BLOCKLEN, 32'h200);
    host.issue(CWD_IDX_WR_MULTI, 32'h800);
    done(0);
    done(0);
    chk(wr_active, 1'b1);
    host.issue(CWD_IDX_STOP, 32'h0);
    chk(wr_active, 1'b0);
    $display("done multi");
  endtask
  // id programming once only, csd programming
  task automatic t_prog();
    host.issue(CWD_IDX_PROG_ID, 32'h0);
    chk(id_prog_en, 1'b1);
    done(0);
    host.issue(CWD_IDX_PROG_ID, 32'h0);
    chk({cmd_illegal, rsp_valid, id_prog_en}, 3'b100);
    host.issue(CWD_IDX_PROG_CSD, 32'h0);
    chk(csd_prog_en, 1'b1);
    rsp(CWD_IDX_PROG_CSD, 1'b0);
    done(0);
    $display("done program");
  endtask
  // protection set, query, clear with busy, then without support
  task automatic t_wp();
    host.issue(CWD_IDX_SET_WP, 32'h35);
    rsp(CWD_IDX_SET_WP, 1'b0);
    host.issue(CWD_IDX_SET_WP, 32'h1F0);
    host.issue(CWD_IDX_SEND_WP, 32'h0);
    chk(wp_send, 1'b1);
    rsp(CWD_IDX_SEND_WP, 1'b0);
    chk(wp_status, 32'h80000008);
    host.issue(CWD_IDX_CLR_WP, 32'h30);
    rsp(CWD_IDX_CLR_WP, 1'b1);
    chk(busy, 1'b1);
    done(1);
    chk(busy, 1'b0);
    chk(wp_status, 32'h80000000);
    wp_supported = 1'b0;
    host.issue(CWD_IDX_SET_WP, 32'h35);
    chk(wp_status, 32'h80000000);
    $display("done protect");
  endtask
  // erase range selection and busy erase
  task automatic t_erase();
    host.issue(CWD_IDX_ERASE_START, 32'h00010000);
    rsp(CWD_IDX_ERASE_START, 1'b0);
    chk(erase_first, 32'h00010000);
    host.issue(CWD_IDX_ERASE_END, 32'h0001FFFF);
    chk(erase_last, 32'h0001FFFF);
    host.issue(CWD_IDX_ERASE, 32'h0);
    chk(erase_go, 1'b1);
    rsp(CWD_IDX_ERASE, 1'b1);
    @(posedge core_clk);
    #1;
    chk(busy, 1'b1);
    done(1);
    chk(busy, 1'b0);
    $display("done erase");
  endtask
  // reserved and io-class indexes refused without a response
  task automatic t_bad();
    logic [5:0] idx_list[6];
    idx_list = '{CWD_IDX_RSV_LO, 6'h21, CWD_IDX_RSV_HI, CWD_IDX_RSV_37, CWD_IDX_IO_LO,
      CWD_IDX_IO_HI};
    foreach (idx_list[i]) begin
      host.issue(idx_list[i], 32'h0);
      chk({cmd_illegal, rsp_valid}, 2'b10);
    end
    $display("done refuse");
  endtask
  // counts and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    t_len();
    t_freeze();
    t_single();
    t_stream();
    t_multi();
    t_prog();
    t_wp();
    t_erase();
    t_bad();
    stop_test();
  end
endmodule
`default_nettype wire
